/* isw_core_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Core model
// ----------------------------------------
// Returns from the service routine a fixed while after each vector, which leaves
// the bench time to clear the serviced flags first.
module isw_core_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Core sequencing
    input  wire logic vector_req,
    output logic      ret_op
);
    logic [3:0] cnt;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= 4'h0;
        end else if (vector_req) begin
            cnt <= 4'hC;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
    // The return is a single pulse; the routine length is fixed by the reload of cnt to 4'hC.
    assign ret_op = (cnt == 4'h1);
endmodule

/* isw_pkg.sv */
package isw_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int INSTR_PERIOD_NS = 40;
    localparam int CLKS_PER_INSTR  = (INSTR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LAT_TICKS       = 3;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTL  = 8'h00;
    localparam logic [7:0] OFS_PFA  = 8'h04;
    localparam logic [7:0] OFS_PFB  = 8'h08;
    localparam logic [7:0] OFS_PEA  = 8'h0C;
    localparam logic [7:0] OFS_PEB  = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_CHG_FLAG  = 0;
    localparam int CTL_EDGE_FLAG = 1;
    localparam int CTL_TMR_FLAG  = 2;
    localparam int CTL_CHG_EN    = 3;
    localparam int CTL_EDGE_EN   = 4;
    localparam int CTL_TMR_EN    = 5;
    localparam int CTL_PERIPH_EN = 6;
    localparam int CTL_GIE       = 7;
    localparam int STAT_PD       = 3;
    localparam int STAT_TO       = 4;

    // ------------------------------------------------------------------
    // Source counts and reset values
    // ------------------------------------------------------------------
    localparam int NUM_SRC    = 14;
    localparam int CORE_SRC   = 3;
    localparam int PFA_BITS   = 8;
    localparam int PFB_BITS   = 3;
    localparam int PERIPH_SRC = PFA_BITS + PFB_BITS;
    localparam int CHG_PINS   = 4;

    localparam logic [2:0]  CTL_FLAG_RST = 3'h0;
    localparam logic [2:0]  CTL_EN_RST   = 3'h0;
    localparam logic [10:0] PERIPH_RST   = 11'h000;
    localparam logic        PD_RST       = 1'b1;
    localparam logic        TO_RST       = 1'b1;
    localparam logic [15:0] VECTOR_ADDR  = 16'h0004;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ISW_IDLE = 2'b01,
        ISW_WAIT = 2'b10
    } isw_vect_e;

    typedef struct packed {
        logic        vector_req;
        logic        push_return;
        logic [15:0] pc_load_addr;
    } isw_core_s;

    typedef struct packed {
        logic asleep;
        logic osc_stop;
        logic io_hold;
        logic wdt_clear;
        logic wake;
    } isw_pwr_s;

endpackage

/* isw_top.sv */
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
module isw_top #(
    parameter int          CLKS_PER_INSTR = isw_pkg::CLKS_PER_INSTR,
    parameter int          LAT_TICKS      = isw_pkg::LAT_TICKS,
    parameter logic [10:0] WAKE_MASK      = 11'h7FF
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // AHB-Lite slave
    input  wire logic                          hsel,
    input  wire logic [7:0]                    haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic [31:0]                        hrdata,
    // Event sources
    input  wire logic                          edge_pin,
    input  wire logic [isw_pkg::CHG_PINS-1:0]  port_change_pins,
    input  wire logic                          timer_zero_evt,
    input  wire logic [isw_pkg::PERIPH_SRC-1:0] periph_evt,
    input  wire logic                          wdt_timeout,
    // Core sequencing
    input  wire logic                          sleep_op,
    input  wire logic                          return_from_irq_op,
    output isw_pkg::isw_core_s                 core_out,
    output logic                               instr_tick,
    // Power control
    output isw_pkg::isw_pwr_s                  pwr_out,
    output logic                               wake_req
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (CLKS_PER_INSTR < 1 || CLKS_PER_INSTR > 256) begin : g_bad_div
        $error("CLKS_PER_INSTR must lie in 1..256");
    end
    if (LAT_TICKS < 1 || LAT_TICKS > 16) begin : g_bad_lat
        $error("LAT_TICKS must lie in 1..16");
    end

    localparam int PINS = isw_pkg::CHG_PINS + 1;
    localparam int LAT_MAX_CYC = 24;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [2:0]                     ctl_flags;
    logic [2:0]                     ctl_en;
    logic                           periph_en;
    logic                           global_irq_enable;
    logic [isw_pkg::PERIPH_SRC-1:0] pflags;
    logic [isw_pkg::PERIPH_SRC-1:0] penables;
    logic                           power_down_flag;
    logic                           time_out_flag;
    logic                           asleep;
    logic [7:0]                     div_cnt;
    logic [3:0]                     lat_cnt;
    isw_pkg::isw_vect_e             vstate;
    logic                           wr_pend;
    logic [7:0]                     wr_addr;
    logic [PINS-1:0]                s1;
    logic [PINS-1:0]                s2;
    logic [PINS-1:0]                s3;
    logic [PINS-1:0]                filt;
    logic [PINS-1:0]                pin_evt;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [PINS-1:0] pins_in;
    assign pins_in = {port_change_pins, edge_pin};

    // Three stages per pin; a change counts only once stages two and three agree.
    for (genvar i = 0; i < PINS; i++) begin : g_sync
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                s1[i]      <= 1'b0;
                s2[i]      <= 1'b0;
                s3[i]      <= 1'b0;
                filt[i]    <= 1'b0;
                pin_evt[i] <= 1'b0;
            end else begin
                s1[i]      <= pins_in[i];
                s2[i]      <= s1[i];
                s3[i]      <= s2[i];
                pin_evt[i] <= (s2[i] == s3[i]) && (s3[i] != filt[i]);
                if (s2[i] == s3[i]) begin
                    filt[i] <= s3[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Event set terms
    // ------------------------------------------------------------------
    logic                           edge_set;
    logic                           change_set;
    logic                           timer_set;
    logic [isw_pkg::PERIPH_SRC-1:0] periph_set;

    // Edge pin counts rising edges of the filtered level; port pins any change.
    assign edge_set   = pin_evt[0] && filt[0];
    assign change_set = |pin_evt[PINS-1:1];
    // clockless sources only
    // The timer needs the on-chip clock, so it cannot flag while asleep.
    assign timer_set  = timer_zero_evt && !asleep;
    assign periph_set = periph_evt & (asleep ? WAKE_MASK : {isw_pkg::PERIPH_SRC{1'b1}});

    // ------------------------------------------------------------------
    // Request combining
    // ------------------------------------------------------------------
    logic core_pend;
    logic periph_pend;
    logic any_pend;
    logic irq_req;
    logic vect_fire;

    assign periph_pend = periph_en && (|(pflags & penables));
    assign core_pend   = |(ctl_flags & ctl_en);
    assign any_pend    = core_pend || periph_pend;
    assign irq_req     = global_irq_enable && any_pend;

    // clockless wake term
    // Pure gates on held flops so the request survives a stopped clock.
    always_comb begin
        wake_req = periph_en && (|(pflags & penables & WAKE_MASK));
        wake_req = wake_req
                || (ctl_flags[isw_pkg::CTL_EDGE_FLAG] && ctl_en[isw_pkg::CTL_EDGE_FLAG])
                || (ctl_flags[isw_pkg::CTL_CHG_FLAG] && ctl_en[isw_pkg::CTL_CHG_FLAG]);
    end

    // ------------------------------------------------------------------
    // Instruction-cycle divider
    // ------------------------------------------------------------------
    // oscillator stops asleep
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt    <= 8'h00;
            instr_tick <= 1'b0;
        end else if (asleep) begin
            div_cnt    <= 8'h00;
            instr_tick <= 1'b0;
        end else if (div_cnt == 8'(CLKS_PER_INSTR - 1)) begin
            div_cnt    <= 8'h00;
            instr_tick <= 1'b1;
        end else begin
            div_cnt    <= div_cnt + 8'h01;
            instr_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Vector latency sequencer
    // ------------------------------------------------------------------
    // enabled request vectors
    // three to four cycles
    // The request is captured on an instruction boundary and vectored a fixed
    // number of boundaries later, so instruction length does not matter.
    assign vect_fire = (vstate == isw_pkg::ISW_WAIT) && instr_tick && irq_req
                    && (lat_cnt == 4'(LAT_TICKS - 1));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vstate  <= isw_pkg::ISW_IDLE;
            lat_cnt <= 4'h0;
        end else begin
            case (vstate)
                isw_pkg::ISW_IDLE: begin
                    if (instr_tick && irq_req) begin
                        vstate  <= isw_pkg::ISW_WAIT;
                        lat_cnt <= 4'h0;
                    end
                end
                isw_pkg::ISW_WAIT: begin
                    if (!irq_req || vect_fire) begin
                        vstate <= isw_pkg::ISW_IDLE;
                    end else if (instr_tick) begin
                        lat_cnt <= lat_cnt + 4'h1;
                    end
                end
                default: begin
                    vstate <= isw_pkg::ISW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_out <= '0;
        end else begin
            core_out.vector_req  <= vect_fire;
            core_out.push_return <= vect_fire;
            if (vect_fire) begin
                core_out.pc_load_addr <= isw_pkg::VECTOR_ADDR;
            end
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    logic        addr_ok;
    logic        wr_ctl;
    logic        wr_pfa;
    logic        wr_pfb;
    logic        wr_pea;
    logic        wr_peb;
    logic [31:0] rd_mux;

    assign addr_ok   = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_ctl    = wr_pend && (wr_addr == isw_pkg::OFS_CTL);
    assign wr_pfa    = wr_pend && (wr_addr == isw_pkg::OFS_PFA);
    assign wr_pfb    = wr_pend && (wr_addr == isw_pkg::OFS_PFB);
    assign wr_pea    = wr_pend && (wr_addr == isw_pkg::OFS_PEA);
    assign wr_peb    = wr_pend && (wr_addr == isw_pkg::OFS_PEB);

    // Read data is sampled in the address phase; zero wait states throughout.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr)
            isw_pkg::OFS_CTL:  rd_mux[7:0] = {global_irq_enable, periph_en, ctl_en, ctl_flags};
            isw_pkg::OFS_PFA:  rd_mux[7:0] = pflags[isw_pkg::PFA_BITS-1:0];
            isw_pkg::OFS_PFB:  rd_mux[2:0] = pflags[isw_pkg::PERIPH_SRC-1:isw_pkg::PFA_BITS];
            isw_pkg::OFS_PEA:  rd_mux[7:0] = penables[isw_pkg::PFA_BITS-1:0];
            isw_pkg::OFS_PEB:  rd_mux[2:0] = penables[isw_pkg::PERIPH_SRC-1:isw_pkg::PFA_BITS];
            isw_pkg::OFS_STAT: begin
                rd_mux[isw_pkg::STAT_PD] = power_down_flag;
                rd_mux[isw_pkg::STAT_TO] = time_out_flag;
            end
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata  <= 32'h0000_0000;
        end else begin
            wr_pend <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr <= haddr;
            end
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // Flag and enable registers
    // ------------------------------------------------------------------
    // set regardless of enables
    // A hardware set in the cycle of a software clear wins.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_flags <= isw_pkg::CTL_FLAG_RST;
            pflags    <= isw_pkg::PERIPH_RST;
        end else begin
            ctl_flags <= (wr_ctl ? hwdata[isw_pkg::CTL_TMR_FLAG:isw_pkg::CTL_CHG_FLAG] : ctl_flags)
                       | {timer_set, edge_set, change_set};
            pflags    <= {wr_pfb ? hwdata[isw_pkg::PFB_BITS-1:0]
                                 : pflags[isw_pkg::PERIPH_SRC-1:isw_pkg::PFA_BITS],
                          wr_pfa ? hwdata[isw_pkg::PFA_BITS-1:0]
                                 : pflags[isw_pkg::PFA_BITS-1:0]}
                       | periph_set;
        end
    end

    // Enables are plain software state.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_en    <= isw_pkg::CTL_EN_RST;
            periph_en <= 1'b0;
            penables  <= isw_pkg::PERIPH_RST;
        end else begin
            if (wr_ctl) begin
                ctl_en    <= hwdata[isw_pkg::CTL_TMR_EN:isw_pkg::CTL_CHG_EN];
                periph_en <= hwdata[isw_pkg::CTL_PERIPH_EN];
            end
            if (wr_pea) begin
                penables[isw_pkg::PFA_BITS-1:0] <= hwdata[isw_pkg::PFA_BITS-1:0];
            end
            if (wr_peb) begin
                penables[isw_pkg::PERIPH_SRC-1:isw_pkg::PFA_BITS] <= hwdata[isw_pkg::PFB_BITS-1:0];
            end
        end
    end

    // return sets enable
    // Accepting a vector outranks a return in the same cycle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            global_irq_enable <= 1'b0;
        end else if (vect_fire) begin
            global_irq_enable <= 1'b0;
        end else if (return_from_irq_op) begin
            global_irq_enable <= 1'b1;
        end else if (wr_ctl) begin
            global_irq_enable <= hwdata[isw_pkg::CTL_GIE];
        end
    end

    // ------------------------------------------------------------------
    // Sleep and wake control
    // ------------------------------------------------------------------
    logic sleep_go;
    logic wake_go;

    assign sleep_go = sleep_op && !asleep && !any_pend;
    // no vector when global enable clear
    // prefetched instruction runs first
    // Wake only clears the sleep state; vectoring follows through the normal
    // sequencer, which already demands a set global enable.
    assign wake_go  = asleep && (wake_req || wdt_timeout);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            asleep  <= 1'b0;
            pwr_out <= '0;
        end else begin
            pwr_out.wdt_clear <= sleep_go;
            pwr_out.wake      <= wake_go;
            if (sleep_go) begin
                asleep <= 1'b1;
            end else if (wake_go) begin
                asleep <= 1'b0;
            end
            pwr_out.asleep   <= sleep_go || (asleep && !wake_go);
            pwr_out.osc_stop <= sleep_go || (asleep && !wake_go);
            pwr_out.io_hold  <= sleep_go || (asleep && !wake_go);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            power_down_flag <= isw_pkg::PD_RST;
            time_out_flag   <= isw_pkg::TO_RST;
        end else if (sleep_go) begin
            power_down_flag <= 1'b0;
            time_out_flag   <= 1'b1;
        end else if (asleep && wdt_timeout) begin
            time_out_flag   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_VECT_CLEARS_GIE: assert property (core_out.vector_req |-> !global_irq_enable)
        else $error("Global enable still set after vector");
    AST_VECT_ADDR: assert property (core_out.vector_req |-> core_out.push_return
        && core_out.pc_load_addr == isw_pkg::VECTOR_ADDR)
        else $error("Vector without push or wrong address");
    AST_VECT_NEEDS_GIE: assert property (core_out.vector_req |-> $past(irq_req))
        else $error("Vector without enabled request");
    AST_FLAG_SETS: assert property ((|periph_set) |=>
        ((pflags & $past(periph_set)) == $past(periph_set)))
        else $error("Peripheral event lost");
    AST_RETURN_GIE: assert property (return_from_irq_op && !vect_fire |=> global_irq_enable)
        else $error("Return did not set global enable");
    AST_SLEEP_ENTRY: assert property (sleep_go |=> asleep && !power_down_flag
        && time_out_flag && pwr_out.wdt_clear && pwr_out.osc_stop)
        else $error("Sleep entry effects missing");
    AST_SLEEP_NOP: assert property (sleep_op && !asleep && any_pend |=> !asleep
        && !pwr_out.wdt_clear && power_down_flag == $past(power_down_flag))
        else $error("Sleep not a no-op with pending request");
    AST_WAKE: assert property (asleep && wake_req |=> !asleep ##1 !pwr_out.io_hold)
        else $error("Enabled source did not wake");
    AST_WDT_WAKE: assert property (asleep && wdt_timeout |=> !asleep && !time_out_flag)
        else $error("Watchdog wake wrong");
    AST_LATENCY: assert property (irq_req && !asleep |-> ##[1:LAT_MAX_CYC]
        (core_out.vector_req || !irq_req))
        else $error("Vector latency exceeded");
    AST_NO_TICK_ASLEEP: assert property (asleep |=> !instr_tick)
        else $error("Instruction clock running asleep");

    COV_VECTOR: cover property (core_out.vector_req);
    COV_SLEEP_WAKE: cover property (sleep_go ##[1:50] wake_go);
    COV_SLEEP_NOP: cover property (sleep_op && any_pend && !asleep);
    COV_WDT_WAKE: cover property (asleep && wdt_timeout);

endmodule

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic clk, rst_n, hsel, hwrite, edge_pin, tz, wdt, slp, ret, hreadyout, hresp, tick, wreq, hit;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, q;
    isw_pkg::isw_core_s core;
    isw_pkg::isw_pwr_s  pwr;
    int n_fail, n_compared, n_vec, i;
    // ----------------------------------------
    // Design and core model
    // ----------------------------------------
    isw_top isw_top_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .edge_pin(edge_pin),
        .port_change_pins(4'h0), .timer_zero_evt(tz), .periph_evt(11'h000), .wdt_timeout(wdt),
        .sleep_op(slp), .return_from_irq_op(ret), .core_out(core), .instr_tick(tick),
        .pwr_out(pwr), .wake_req(wreq));
    isw_core_model isw_core_model_inst (.clk(clk), .rst_n(rst_n),
        .vector_req(core.vector_req), .ret_op(ret));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Vectors are counted so that a stray one is visible.
    always @(posedge clk) if (core.vector_req === 1'b1) n_vec++;
    task results;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task ck(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One AHB-Lite single word transfer; read data lands in q.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
        for (i = 0; i < 9; i++) begin @(posedge clk); if (hreadyout === 1'b1) break; end
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        for (i = 0; i < 9; i++) begin @(posedge clk); if (hreadyout === 1'b1) break; end
        q = hrdata;
        if (i == 9) ck(32'h0, 32'h1);
        ck(hresp, 1'b0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        ck(q, e);
    endtask
    task pulse(input logic [2:0] m);
        @(posedge clk); {wdt, slp, tz} <= m;
        @(posedge clk); {wdt, slp, tz} <= 3'h0;
    endtask
    task wt(input bit wk, input int n);
        hit = 1'b0;
        for (i = 0; i < n && !hit; i++) begin
            @(negedge clk);
            hit = wk ? (pwr.wake === 1'b1) : (core.vector_req === 1'b1);
        end
    endtask
    // Flag sets with everything masked, and nothing vectors.
    task t_flag;
        n_vec = 0;
        pulse(3'h1);
        repeat (30) @(posedge clk);
        rd(8'h00, 32'h04);
        ck(n_vec, 0);
        bus(1'b1, 8'h00, 32'h0);
        $display("flag test done");
    endtask
    // Vector, return, then a mid-run reset with the global enable set.
    task t_vec;
        bus(1'b1, 8'h00, 32'hA0);
        pulse(3'h1);
        wt(0, 60);
        ck(hit, 1);
        ck(i inside {[12:18]}, 1);
        ck(core.pc_load_addr, 32'h4);
        ck(core.push_return, 1);
        rd(8'h00, 32'h24);
        bus(1'b1, 8'h00, 32'h20);
        repeat (16) @(posedge clk);
        rd(8'h00, 32'hA0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h00, 32'h0);
        $display("vector test done");
    endtask
    // Sleep, wake on the edge pin without vectoring, then a watchdog wake.
    task t_sleep;
        repeat (4) @(posedge clk);
        bus(1'b1, 8'h00, 32'h10);
        pulse(3'h2);
        @(negedge clk);
        ck(pwr.asleep & pwr.osc_stop & pwr.io_hold, 1);
        ck(pwr.wdt_clear, 1);
        n_vec = 0;
        edge_pin <= 1'b1;
        wt(1, 20);
        ck(hit, 1);
        ck(wreq, 1);
        repeat (40) @(posedge clk);
        ck(n_vec, 0);
        edge_pin <= 1'b0;
        rd(8'h14, 32'h10);
        bus(1'b1, 8'h00, 32'h0);
        pulse(3'h2);
        pulse(3'h4);
        rd(8'h14, 32'h0);
        $display("sleep test done");
    endtask
    // A pending enabled request turns sleep into a no-operation.
    task t_nop;
        bus(1'b1, 8'h00, 32'h20);
        pulse(3'h1);
        pulse(3'h2);
        @(negedge clk);
        ck(pwr.asleep, 0);
        rd(8'h14, 32'h0);
        $display("no-op test done");
    endtask
    initial begin
        rst_n = 1'b0; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; haddr = 8'h00;
        hwdata = 32'h0; edge_pin = 1'b0; tz = 1'b0; wdt = 1'b0; slp = 1'b0;
        n_fail = 0; n_compared = 0; n_vec = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'h14, 32'h18);
        rd(8'h00, 32'h0);
        rd(8'h18, 32'h0);
        t_flag;
        t_vec;
        t_sleep;
        t_nop;
        results;
    end
endmodule
